//--- src/clk_mode_pkg.sv
// Constants, types and register map of the system clock and power mode block.
package clk_mode_pkg;

    // ****************************************************************
    // Register map and field layout.
    // ****************************************************************
    localparam int         ADDR_W          = 2;
    localparam int         DATA_W          = 8;
    localparam logic [1:0] CLK_CTRL_ADDR   = 2'h0;
    localparam logic [1:0] OSC_CTRL_ADDR   = 2'h1;
    localparam logic [1:0] STATUS_ADDR     = 2'h2;
    localparam int         DIV_SEL_MSB     = 7;
    localparam int         DIV_SEL_LSB     = 5;
    localparam int         HS_SRC_BIT      = 3;
    localparam int         LS_SRC_BIT      = 2;
    localparam int         HS_KEEP_BIT     = 1;
    localparam int         LS_KEEP_BIT     = 0;
    localparam int         HS_OSC_EN_BIT   = 0;
    localparam int         WDOG_EN_BIT     = 1;
    localparam logic [7:0] CLK_CTRL_RESET  = 8'h00;
    localparam logic [7:0] OSC_CTRL_RESET  = 8'h01;

    // ****************************************************************
    // Clock selection codes.
    // ****************************************************************
    localparam logic [2:0] DIV_SEL_SUB     = 3'h7;
    localparam int         HS_DIV_CNT_W    = 6;
    localparam logic       SRC_INT_RC      = 1'b0;
    localparam logic       SRC_EXT_XTAL    = 1'b1;

    // ****************************************************************
    // Operating modes as reported in the status register.
    // ****************************************************************
    typedef enum logic [2:0] {
        MODE_FAST          = 3'b000,
        MODE_SLOW          = 3'b001,
        MODE_SLEEP         = 3'b010,
        MODE_IDLE_LS_ONLY  = 3'b011,
        MODE_IDLE_BOTH_OSC = 3'b100,
        MODE_IDLE_HS_ONLY  = 3'b101
    } op_mode_type;

    typedef struct packed {
        logic cpu;
        logic sys;
        logic hs;
        logic sub;
        logic ls_rc;
    } clk_run_type;

    typedef struct packed {
        logic ext_hs_crystal_osc;
        logic int_hs_rc_osc;
        logic ext_ls_crystal_osc;
        logic int_ls_rc_osc;
    } osc_en_type;

endpackage

//--- src/sysclk_select_power_modes.sv
// System clock selection, divider and halt power mode control.
//
// Overview of operation
// - Select code 000-110 gives divided high-speed clock; 111 gives sub clock.
// - One source bit picks crystal or RC for the high-speed clock.
// - One source bit picks crystal or RC for the sub clock.
// - Moving to the sub clock stops or keeps high-speed oscillator per enable.
// - Six modes: fast, slow, sleep and three idle modes entered by halt.
// - Fast mode runs CPU from divided high-speed clock; all clocks run.
// - Slow mode runs CPU from sub clock; high-speed clock follows its enable.
// - Halt with both keep bits low enters sleep, stopping CPU and clocks.
// - In sleep the low-speed RC clock runs only with watchdog enabled.
// - Halt with only low-speed keep: high-speed off, system clock only on 111.
// - Halt with both keep bits high keeps every clock except the CPU.
// - Halt with only high-speed keep: sub off, system clock only below 111.
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module sysclk_select_power_modes
    import clk_mode_pkg::*;
#(
    parameter int DIV_W = HS_DIV_CNT_W
) (
    input  wire logic                sys_clk,
    input  wire logic                rst_b,
    input  wire logic [ADDR_W-1:0]   reg_addr,
    input  wire logic [DATA_W-1:0]   reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [DATA_W-1:0]   reg_rdata,
    input  wire logic                halt_req,
    input  wire logic                wake_req,
    input  wire logic                ext_hs_tick,
    input  wire logic                int_hs_tick,
    input  wire logic                ext_ls_tick,
    input  wire logic                int_ls_tick,
    output logic                     hs_clock_tick,
    output logic                     sub_clock_tick,
    output logic                     ls_rc_clock_tick,
    output logic                     sys_clock_tick,
    output logic                     cpu_clock_tick,
    output clk_run_type              clk_run,
    output osc_en_type               osc_en,
    output op_mode_type              op_mode
);

    // ****************************************************************
    // Elaboration check.
    // ****************************************************************
    // The divider must reach the largest ratio of 64.
    if (DIV_W < HS_DIV_CNT_W) begin : g_bad_div_w
        $error("DIV_W too small for the largest divide ratio.");
    end

    // The status word packs the clock run flags above the mode code.
    if ($bits(clk_run_type) + $bits(op_mode_type) != DATA_W) begin : g_bad_status_w
        $error("Status word does not fit the data width.");
    end

    // ****************************************************************
    // Functions.
    // ****************************************************************
    // Mask of divider bits that must be all ones for a system tick.
    function automatic logic [DIV_W-1:0] div_mask(input logic [2:0] sel);
        logic [DIV_W-1:0] m;
        m = '0;
        for (int i = 0; i < HS_DIV_CNT_W; i++) begin
            if (i < int'(sel)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // Picks crystal or RC according to a source select bit.
    function automatic logic pick_src(input logic src_sel, input logic xtal,
                                      input logic rc);
        return (src_sel == SRC_EXT_XTAL) ? xtal : rc;
    endfunction

    // ****************************************************************
    // Registers.
    // ****************************************************************
    logic [DATA_W-1:0] sys_clk_ctrl_reg;
    logic [DATA_W-1:0] sys_clk_ctrl_next;
    logic [DATA_W-1:0] osc_ctrl_reg;
    logic [DATA_W-1:0] osc_ctrl_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic [DIV_W-1:0]  div_cnt_reg;
    logic [DIV_W-1:0]  div_cnt_next;
    op_mode_type       mode_reg;
    op_mode_type       mode_next;
    clk_run_type       run_reg;
    clk_run_type       run_next;
    osc_en_type        osc_en_reg;
    osc_en_type        osc_en_next;
    logic              hs_tick_reg;
    logic              sub_tick_reg;
    logic              ls_rc_tick_reg;
    logic              sys_tick_reg;
    logic              cpu_tick_reg;

    // ****************************************************************
    // Register fields.
    // ****************************************************************
    wire logic [2:0] sysclk_div_sel  = sys_clk_ctrl_reg[DIV_SEL_MSB:DIV_SEL_LSB];
    wire logic       hs_src_sel      = sys_clk_ctrl_reg[HS_SRC_BIT];
    wire logic       ls_src_sel      = sys_clk_ctrl_reg[LS_SRC_BIT];
    wire logic       hs_keep_on_halt = sys_clk_ctrl_reg[HS_KEEP_BIT];
    wire logic       ls_keep_on_halt = sys_clk_ctrl_reg[LS_KEEP_BIT];
    wire logic       hs_osc_en       = osc_ctrl_reg[HS_OSC_EN_BIT];
    wire logic       watchdog_en     = osc_ctrl_reg[WDOG_EN_BIT];
    wire logic       sel_is_sub      = (sysclk_div_sel == DIV_SEL_SUB);

    // ****************************************************************
    // Register bus decode.
    // ****************************************************************
    wire logic wr_cctrl = reg_wr && (reg_addr == CLK_CTRL_ADDR);
    wire logic wr_octrl = reg_wr && (reg_addr == OSC_CTRL_ADDR);

    // The bit just below the select field is unimplemented and reads zero.
    localparam int UNUSED_BIT = DIV_SEL_LSB - 1;
    wire logic [DATA_W-1:0] cctrl_wmask = ~(8'h01 << UNUSED_BIT);
    wire logic [DATA_W-1:0] octrl_wmask = (8'h01 << HS_OSC_EN_BIT)
                                        | (8'h01 << WDOG_EN_BIT);

    assign sys_clk_ctrl_next = wr_cctrl ? (reg_wdata & cctrl_wmask)
                                        : sys_clk_ctrl_reg;
    assign osc_ctrl_next = wr_octrl ? (reg_wdata & octrl_wmask)
                                    : osc_ctrl_reg;

    wire logic [DATA_W-1:0] status_word = {run_reg, mode_reg};

    always_comb begin
        rdata_next = '0;
        if (reg_rd) begin
            case (reg_addr)
                CLK_CTRL_ADDR: rdata_next = sys_clk_ctrl_reg;
                OSC_CTRL_ADDR: rdata_next = osc_ctrl_reg;
                STATUS_ADDR:   rdata_next = status_word;
                default:       rdata_next = '0;
            endcase
        end
    end

    // ****************************************************************
    // Operating mode state machine.
    // ****************************************************************
    wire logic         cpu_running = (mode_reg == MODE_FAST)
                                  || (mode_reg == MODE_SLOW);
    wire op_mode_type  run_mode    = sel_is_sub ? MODE_SLOW : MODE_FAST;

    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            MODE_FAST, MODE_SLOW: begin
                if (halt_req) begin
                    case ({hs_keep_on_halt, ls_keep_on_halt})
                        2'b00:   mode_next = MODE_SLEEP;
                        2'b01:   mode_next = MODE_IDLE_LS_ONLY;
                        2'b11:   mode_next = MODE_IDLE_BOTH_OSC;
                        default: mode_next = MODE_IDLE_HS_ONLY;
                    endcase
                end else begin
                    mode_next = run_mode;
                end
            end
            MODE_SLEEP, MODE_IDLE_LS_ONLY, MODE_IDLE_BOTH_OSC,
            MODE_IDLE_HS_ONLY: begin
                if (wake_req) begin
                    mode_next = run_mode;
                end
            end
            default: mode_next = run_mode;
        endcase
    end

    // ****************************************************************
    // Clock gating per mode.
    // ****************************************************************
    always_comb begin
        run_next = '0;
        case (mode_next)
            MODE_FAST: begin
                run_next.cpu   = 1'b1;
                run_next.sys   = 1'b1;
                run_next.hs    = 1'b1;
                run_next.sub   = 1'b1;
                run_next.ls_rc = 1'b1;
            end
            MODE_SLOW: begin
                run_next.cpu   = 1'b1;
                run_next.sys   = 1'b1;
                run_next.sub   = 1'b1;
                run_next.ls_rc = 1'b1;
                run_next.hs    = hs_osc_en;
            end
            MODE_SLEEP: begin
                run_next.sys   = 1'b0;
                run_next.hs    = 1'b0;
                run_next.sub   = 1'b0;
                run_next.ls_rc = watchdog_en;
            end
            MODE_IDLE_LS_ONLY: begin
                run_next.sys   = sel_is_sub;
                run_next.hs    = 1'b0;
                run_next.sub   = 1'b1;
                run_next.ls_rc = 1'b1;
            end
            MODE_IDLE_BOTH_OSC: begin
                run_next.sys   = 1'b1;
                run_next.hs    = 1'b1;
                run_next.sub   = 1'b1;
                run_next.ls_rc = 1'b1;
            end
            MODE_IDLE_HS_ONLY: begin
                run_next.sys   = !sel_is_sub;
                run_next.hs    = 1'b1;
                run_next.sub   = 1'b0;
                run_next.ls_rc = 1'b1;
            end
            default: run_next = '0;
        endcase
    end

    // ****************************************************************
    // Oscillator enables.
    // ****************************************************************
    // High-speed and low-speed source choice.
    assign osc_en_next.ext_hs_crystal_osc = run_next.hs
                                         && (hs_src_sel == SRC_EXT_XTAL);
    assign osc_en_next.int_hs_rc_osc      = run_next.hs
                                         && (hs_src_sel == SRC_INT_RC);
    assign osc_en_next.ext_ls_crystal_osc = run_next.sub
                                         && (ls_src_sel == SRC_EXT_XTAL);
    // The low-speed RC also feeds the watchdog, so it may run alone.
    assign osc_en_next.int_ls_rc_osc      = run_next.ls_rc
                                         || (run_next.sub
                                         && (ls_src_sel == SRC_INT_RC));

    // ****************************************************************
    // Clock ticks and divider.
    // ****************************************************************
    // High-speed and sub tick selection.
    wire logic hs_src_tick  = pick_src(hs_src_sel, ext_hs_tick, int_hs_tick);
    wire logic sub_src_tick = pick_src(ls_src_sel, ext_ls_tick, int_ls_tick);
    wire logic hs_tick_on   = hs_src_tick && run_reg.hs;
    wire logic sub_tick_on  = sub_src_tick && run_reg.sub;
    wire logic lrc_tick_on  = int_ls_tick && run_reg.ls_rc;

    wire logic [DIV_W-1:0] cur_mask  = div_mask(sysclk_div_sel);
    wire logic             div_wrap  = ((div_cnt_reg & cur_mask) == cur_mask);
    wire logic             div_tick  = hs_tick_on && div_wrap;

    // The divider counts only while the high-speed clock runs.
    assign div_cnt_next = hs_tick_on ? (div_cnt_reg + 1'b1) : div_cnt_reg;

    wire logic sys_src_tick = sel_is_sub ? sub_src_tick : div_tick;
    wire logic sys_tick_on  = sys_src_tick && run_reg.sys
                           && (sel_is_sub ? run_reg.sub : run_reg.hs);

    // The processor only sees system ticks while a running mode holds.
    wire logic cpu_tick_on  = sys_tick_on && run_reg.cpu && cpu_running;

    // ****************************************************************
    // Flip-flops.
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sys_clk_ctrl_reg <= CLK_CTRL_RESET;
            osc_ctrl_reg     <= OSC_CTRL_RESET;
            rdata_reg        <= '0;
        end else begin
            sys_clk_ctrl_reg <= sys_clk_ctrl_next;
            osc_ctrl_reg     <= osc_ctrl_next;
            rdata_reg        <= rdata_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_reg   <= MODE_FAST;
            run_reg    <= '1;
            osc_en_reg <= '0;
        end else begin
            mode_reg   <= mode_next;
            run_reg    <= run_next;
            osc_en_reg <= osc_en_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt_reg    <= '0;
            hs_tick_reg    <= 1'b0;
            sub_tick_reg   <= 1'b0;
            ls_rc_tick_reg <= 1'b0;
            sys_tick_reg   <= 1'b0;
            cpu_tick_reg   <= 1'b0;
        end else begin
            div_cnt_reg    <= div_cnt_next;
            hs_tick_reg    <= hs_tick_on;
            sub_tick_reg   <= sub_tick_on;
            ls_rc_tick_reg <= lrc_tick_on;
            sys_tick_reg   <= sys_tick_on;
            cpu_tick_reg   <= cpu_tick_on;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    assign reg_rdata        = rdata_reg;
    assign hs_clock_tick    = hs_tick_reg;
    assign sub_clock_tick   = sub_tick_reg;
    assign ls_rc_clock_tick = ls_rc_tick_reg;
    assign sys_clock_tick   = sys_tick_reg;
    assign cpu_clock_tick   = cpu_tick_reg;
    assign clk_run          = run_reg;
    assign osc_en           = osc_en_reg;
    assign op_mode          = mode_reg;

endmodule

`default_nettype wire

//--- dv/sysclk_select_power_modes_props.sv
// Concurrent checks on the ports of the clock and power mode block.
`timescale 1ns/1ps
`default_nettype none

module sysclk_select_power_modes_props
    import clk_mode_pkg::*;
#(
    parameter int DIV_W = HS_DIV_CNT_W
) (
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic        halt_req,
    input wire logic        wake_req,
    input wire logic        hs_clock_tick,
    input wire logic        sub_clock_tick,
    input wire logic        cpu_clock_tick,
    input wire clk_run_type clk_run,
    input wire op_mode_type op_mode
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    wire logic running = (op_mode == MODE_FAST) || (op_mode == MODE_SLOW);

    fast_all_on_a: assert property (op_mode == MODE_FAST |-> clk_run == 5'h1f)
        else $error("fast mode with a clock stopped");
    slow_sub_on_a: assert property (op_mode == MODE_SLOW |-> clk_run.cpu && clk_run.sys
        && clk_run.sub && clk_run.ls_rc) else $error("slow mode clocks wrong");
    sleep_off_a: assert property (op_mode == MODE_SLEEP |-> clk_run[4:1] == 4'h0)
        else $error("sleep mode with a clock running");
    idle_ls_a: assert property (op_mode == MODE_IDLE_LS_ONLY |-> !clk_run.cpu
        && !clk_run.hs && clk_run.sub && clk_run.ls_rc) else $error("low-speed idle wrong");
    idle_both_a: assert property (op_mode == MODE_IDLE_BOTH_OSC |-> clk_run == 5'h0f)
        else $error("dual idle clocks wrong");
    idle_hs_a: assert property (op_mode == MODE_IDLE_HS_ONLY |-> !clk_run.cpu
        && clk_run.hs && !clk_run.sub && clk_run.ls_rc) else $error("high-speed idle wrong");
    halt_entry_a: assert property (halt_req && running |=> !running)
        else $error("halt did not stop the processor");
    halt_hold_a: assert property (!running && !wake_req |=> !running)
        else $error("left a halted mode without wake");
    wake_exit_a: assert property (wake_req && !running |=> running && clk_run.cpu)
        else $error("wake did not restart the processor");
    cpu_tick_gate_a: assert property (cpu_clock_tick |-> $past(running))
        else $error("processor tick while halted");
    hs_tick_gate_a: assert property (hs_clock_tick |-> $past(clk_run.hs))
        else $error("high-speed tick while stopped");
    sub_tick_gate_a: assert property (sub_clock_tick |-> $past(clk_run.sub))
        else $error("sub tick while stopped");

    cover property (op_mode == MODE_SLEEP);
    cover property (op_mode == MODE_IDLE_BOTH_OSC ##1 running);
    cover property (sub_clock_tick && op_mode == MODE_IDLE_LS_ONLY);
endmodule

bind sysclk_select_power_modes sysclk_select_power_modes_props #(.DIV_W(DIV_W))
    i_sysclk_select_power_modes_props (.sys_clk(sys_clk), .rst_b(rst_b),
    .halt_req(halt_req), .wake_req(wake_req), .hs_clock_tick(hs_clock_tick),
    .sub_clock_tick(sub_clock_tick), .cpu_clock_tick(cpu_clock_tick),
    .clk_run(clk_run), .op_mode(op_mode));

`default_nettype wire

//--- dv/cpu_core_model.sv
// Processor core model that issues register accesses, halt and wake.
`timescale 1ns/1ps
`default_nettype none

module cpu_core_model
    import clk_mode_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic [DATA_W-1:0] reg_rdata,
    output var logic  [ADDR_W-1:0] reg_addr,
    output var logic  [DATA_W-1:0] reg_wdata,
    output var logic               reg_wr,
    output var logic               reg_rd,
    output var logic               halt_req,
    output var logic               wake_req
);
    initial begin
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        halt_req = 1'b0;
        wake_req = 1'b0;
    end

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic pulse(input logic is_halt);
        @(posedge sys_clk);
        halt_req <= is_halt;
        wake_req <= !is_halt;
        @(posedge sys_clk);
        halt_req <= 1'b0;
        wake_req <= 1'b0;
    endtask
endmodule

`default_nettype wire

//--- dv/sysclk_select_power_modes_tb.sv
// Self-checking testbench of the clock and power mode block.
`timescale 1ns/1ps
`default_nettype none

module sysclk_select_power_modes_tb
    import clk_mode_pkg::*;
;
    logic              sys_clk = 1'b0;
    logic              rst_b = 1'b0;
    logic              ext_hs_tick = 1'b1;
    logic              int_hs_tick = 1'b1;
    logic              ext_ls_tick = 1'b1;
    logic              int_ls_tick = 1'b1;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic [DATA_W-1:0] reg_rdata;
    logic              reg_wr;
    logic              reg_rd;
    logic              halt_req;
    logic              wake_req;
    logic              hs_t;
    logic              sub_t;
    logic              sys_t;
    logic              cpu_t;
    logic              lrc_t;
    osc_en_type        osc_en;
    clk_run_type       clk_run;
    op_mode_type       op_mode;
    int                n_fail = 0;
    int                check_count = 0;

    always #2.5 sys_clk = ~sys_clk;

    sysclk_select_power_modes i_sysclk_select_power_modes (.sys_clk(sys_clk), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .halt_req(halt_req), .wake_req(wake_req),
        .ext_hs_tick(ext_hs_tick), .int_hs_tick(int_hs_tick), .ext_ls_tick(ext_ls_tick),
        .int_ls_tick(int_ls_tick), .hs_clock_tick(hs_t), .sub_clock_tick(sub_t),
        .ls_rc_clock_tick(lrc_t), .sys_clock_tick(sys_t), .cpu_clock_tick(cpu_t),
        .clk_run(clk_run), .osc_en(osc_en), .op_mode(op_mode));

    cpu_core_model i_cpu_core_model (.sys_clk(sys_clk), .reg_rdata(reg_rdata),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .halt_req(halt_req), .wake_req(wake_req));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic settle();
        repeat (3) @(posedge sys_clk);
    endtask

    // Counts the high-speed, sub, system and processor ticks over a window.
    task automatic count(input int cyc, output int nh, output int ns, output int ny,
                         output int nc);
        nh = 0;
        ns = 0;
        ny = 0;
        nc = 0;
        repeat (cyc) begin
            @(posedge sys_clk);
            #1;
            nh += (hs_t === 1'b1);
            ns += (sub_t === 1'b1);
            ny += (sys_t === 1'b1);
            nc += (cpu_t === 1'b1);
        end
    endtask

    task automatic t_regs();
        logic [7:0] d;
        i_cpu_core_model.rd(CLK_CTRL_ADDR, d);
        chk(d, CLK_CTRL_RESET, "control reset");
        i_cpu_core_model.rd(OSC_CTRL_ADDR, d);
        chk(d, OSC_CTRL_RESET, "oscillator control reset");
        i_cpu_core_model.wr(2'h3, 8'hff);
        i_cpu_core_model.rd(2'h3, d);
        chk(d, 8'h00, "unmapped read");
        i_cpu_core_model.rd(STATUS_ADDR, d);
        chk(d, 8'hf8, "status after reset");
        i_cpu_core_model.wr(CLK_CTRL_ADDR, 8'hff);
        i_cpu_core_model.rd(CLK_CTRL_ADDR, d);
        chk(d, 8'hef, "control write readback");
        i_cpu_core_model.wr(OSC_CTRL_ADDR, 8'hff);
        i_cpu_core_model.rd(OSC_CTRL_ADDR, d);
        chk(d, 8'h03, "oscillator control readback");
        i_cpu_core_model.rd(STATUS_ADDR, d);
        chk(d, 8'hf9, "status in slow mode");
    endtask

    task automatic t_div();
        int nh, ns, ny, nc;
        logic [7:0] ex;
        for (int s = 0; s < 8; s++) begin
            i_cpu_core_model.wr(CLK_CTRL_ADDR, {3'(s), 5'h00});
            settle();
            count(128, nh, ns, ny, nc);
            ex = (s < 7) ? 8'(32'h80 >> s) : 8'h80;
            chk(8'(ny), ex, "system tick count");
            chk(8'(nc), ex, "processor tick count");
            chk({5'h0, op_mode}, (s < 7) ? 8'h00 : 8'h01, "running mode");
            chk({3'h0, clk_run}, 8'h1f, "running clocks");
        end
    endtask

    task automatic t_src();
        int nh, ns, ny, nc;
        @(posedge sys_clk);
        int_hs_tick <= 1'b0;
        int_ls_tick <= 1'b0;
        for (int b = 0; b < 4; b++) begin
            i_cpu_core_model.wr(CLK_CTRL_ADDR, 8'(b << 2));
            settle();
            count(16, nh, ns, ny, nc);
            chk(8'(nh), b[1] ? 8'h10 : 8'h00, "high-speed source");
            chk(8'(ns), b[0] ? 8'h10 : 8'h00, "low-speed source");
        end
        @(posedge sys_clk);
        int_hs_tick <= 1'b1;
        int_ls_tick <= 1'b1;
    endtask

    task automatic t_slow();
        int nh, ns, ny, nc;
        for (int e = 0; e < 3; e++) begin
            i_cpu_core_model.wr(OSC_CTRL_ADDR, {7'h0, e[0]});
            i_cpu_core_model.wr(CLK_CTRL_ADDR, (e < 2) ? 8'he0 : 8'h00);
            settle();
            count(16, nh, ns, ny, nc);
            chk(8'(nh), (e == 0) ? 8'h00 : 8'h10, "high-speed run by enable");
            chk({4'h0, osc_en}, {5'h0, e != 0, 2'b01}, "oscillator enables");
        end
    endtask

    task automatic t_halt();
        int nh, ns, ny, nc;
        logic [3:0] v;
        logic [1:0] k;
        logic       sy;
        logic       ls;
        op_mode_type mt [4];
        mt = '{MODE_SLEEP, MODE_IDLE_LS_ONLY, MODE_IDLE_HS_ONLY, MODE_IDLE_BOTH_OSC};
        for (int i = 0; i < 16; i++) begin
            v = 4'(i);
            k = v[1:0];
            sy = (k == 2'b11) || (k == 2'b01 && v[3]) || (k == 2'b10 && !v[3]);
            ls = (k != 2'b00) || v[2];
            i_cpu_core_model.wr(OSC_CTRL_ADDR, {6'h0, v[2], 1'b1});
            i_cpu_core_model.wr(CLK_CTRL_ADDR, {v[3] ? 3'h7 : 3'h0, 3'h0, k});
            settle();
            i_cpu_core_model.pulse(1'b1);
            i_cpu_core_model.pulse(1'b1);
            count(8, nh, ns, ny, nc);
            chk({5'h0, op_mode}, 8'(mt[k]), "halt mode");
            chk({3'h0, clk_run}, {4'h0, sy, k, (k != 2'b00) || v[2]}, "halt clocks");
            chk(8'(nc), 8'h00, "processor tick in halt");
            chk(8'(nh), k[1] ? 8'h08 : 8'h00, "high-speed tick in halt");
            chk(8'(ns), k[0] ? 8'h08 : 8'h00, "sub tick in halt");
            chk(8'(ny), sy ? 8'h08 : 8'h00, "system tick in halt");
            chk({7'h0, lrc_t}, {7'h0, ls}, "RC tick in halt");
            chk({4'h0, osc_en}, {5'h0, k[1], 1'b0, ls}, "halt oscillators");
            i_cpu_core_model.pulse(1'b0);
            settle();
            chk({5'h0, op_mode}, v[3] ? 8'h01 : 8'h00, "wake mode");
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #200000;
        n_fail++;
        $display("[ERR] %0t run did not complete", $time);
        finish_test();
    end

    initial begin
        repeat (10) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_regs();
        t_div();
        t_src();
        t_slow();
        t_halt();
        finish_test();
    end
endmodule

`default_nettype wire
